// ---- verilog/pfa_ctrl.sv ----
// Program flash self-access controller top
`timescale 1ns/10ps
`default_nettype none
`include "pfa_defs.svh"
module pfa_ctrl #(
  parameter int ROW_WORDS = `PFA_ROW_WORDS,
  parameter logic [`PFA_ADDR_W-1:0] BOOT_END = 15'h0400,
  parameter logic [`PFA_ADDR_W-1:0] SAF_START = 15'h0f80
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Address, data and control register writes from the core
  input wire logic flash_addr_high_wr,
  input wire logic flash_addr_low_wr,
  input wire logic flash_data_high_wr,
  input wire logic flash_data_low_wr,
  input wire logic [`PFA_BYTE_W-1:0] reg_wdata,
  input wire logic config_space_select,
  input wire logic erase_select,
  input wire logic write_permit,
  input wire logic read_start_set,
  input wire logic write_start_set,
  input wire logic unlock_key_register_wr,
  input wire logic disturb,
  input wire logic done_flag_clear,
  input wire logic flash_op_irq_enable,
  // Register read-back
  output logic [`PFA_ADDR_W-1:0] flash_addr,
  output logic [`PFA_WORD_W-1:0] flash_data,
  output logic read_start,
  output logic write_start,
  output logic flash_op_done_flag,
  output logic flash_op_irq,
  // Indirect access through the pointer register
  input wire logic ind_rd_req,
  input wire logic ind_wr_req,
  input wire logic [`PFA_ADDR_W:0] pointer_register,
  output logic [`PFA_BYTE_W-1:0] indirect_data_port,
  output logic ind_rd_valid,
  // Core stall
  output logic cpu_stall,
  // Configuration protection bits
  input wire logic code_protect,
  input wire logic storage_area_write_protect,
  input wire logic config_write_protect,
  input wire logic boot_write_protect,
  input wire logic app_write_protect,
  // External programmer gating
  input wire logic ext_bulk_erase_req,
  output logic ext_access_allowed,
  output logic ext_bulk_erase,
  // Flash array with its timer and pump
  output logic array_rd,
  output logic array_erase_row,
  output logic array_prog,
  output logic array_space,
  output logic [`PFA_ADDR_W-1:0] array_addr,
  output logic [`PFA_WORD_W-1:0] array_wdata,
  input wire logic [`PFA_WORD_W-1:0] array_rdata,
  input wire logic array_done
);
  import pfa_pkg::*;

  pfa_state_t state;
  pfa_state_t next_state;
  logic [`PFA_ADDR_W-1:0] next_flash_addr;
  logic [`PFA_WORD_W-1:0] next_flash_data;
  logic next_read_start;
  logic next_write_start;
  logic next_done_flag;
  logic [`PFA_BYTE_W-1:0] next_ind_data;
  logic next_ind_valid;
  logic [ROW_WORDS-1:0] latch_valid;
  logic [ROW_WORDS-1:0] next_latch_valid;
  logic [`PFA_ROW_IDX_W-1:0] idx;
  logic [`PFA_ROW_IDX_W-1:0] next_idx;
  logic [`PFA_WORD_W-1:0] latch_rdata;
  logic [`PFA_WORD_W-1:0] next_wdata;
  logic unlock_ok;
  logic protected_addr;
  logic latch_we;
  logic [`PFA_WORD_W-1:0] latch_word;

  // ------------------------------------------------------------
  // Submodules
  // ------------------------------------------------------------
  // Software never sees the latches: they fill only from data-low writes
  assign latch_we = flash_data_low_wr && state == pfa_idle;
  assign latch_word = {flash_data[`PFA_WORD_W-1:`PFA_BYTE_W], reg_wdata};

  pfa_latch_mem #(.DEPTH(ROW_WORDS), .AW(`PFA_ROW_IDX_W), .DW(`PFA_WORD_W)) u_latch (
    .clock(clock),
    .rst_n(rst_n),
    .we(latch_we),
    .waddr(flash_addr[`PFA_ROW_IDX_W-1:0]),
    .wdata(latch_word),
    .raddr(next_idx),
    .rdata(latch_rdata)
  );

  pfa_unlock u_unlock (
    .clock(clock),
    .rst_n(rst_n),
    .key_wr(unlock_key_register_wr),
    .key_data(reg_wdata),
    .write_start_set(write_start_set),
    .disturb(disturb),
    .unlock_ok(unlock_ok)
  );

  // ------------------------------------------------------------
  // Protection
  // ------------------------------------------------------------
  always_comb
  begin
    if (config_space_select)
      // Only user IDs are writable; revision, device ID, config are read-only
      protected_addr = config_write_protect || flash_addr >= `PFA_USER_ID_COUNT;
    else
      protected_addr = (boot_write_protect && flash_addr < BOOT_END) ||
                       (app_write_protect && flash_addr >= BOOT_END && flash_addr < SAF_START) ||
                       (storage_area_write_protect && flash_addr >= SAF_START);
  end

  // External programmers ignore write protection but respect code protection
  assign ext_access_allowed = !code_protect;
  // Bulk erase only ever comes from outside; it also clears code protection in the array
  assign ext_bulk_erase = ext_bulk_erase_req;

  // ------------------------------------------------------------
  // Array and core handshakes
  // ------------------------------------------------------------
  // Indirect writes are deliberately absent: ind_wr_req drives nothing
  // The array answers one cycle after array_rd, so both reads ask from idle
  assign array_rd = state == pfa_idle && (ind_rd_req || read_start_set);
  assign array_space = (state == pfa_idle && ind_rd_req) ? 1'b0 : config_space_select;
  assign array_addr = (state == pfa_idle && ind_rd_req) ? pointer_register[`PFA_ADDR_W-1:0]
                                                        : flash_addr;
  assign array_erase_row = state == pfa_idle && unlock_ok && write_permit && erase_select &&
                           !protected_addr;
  assign array_prog = state == pfa_prog_issue;
  assign cpu_stall = (state != pfa_idle && state != pfa_ind) || (state == pfa_idle && ind_rd_req) ||
                     array_erase_row;
  assign flash_op_irq = flash_op_done_flag && flash_op_irq_enable;

  // ------------------------------------------------------------
  // Controller next state
  // ------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_flash_addr = flash_addr;
    next_flash_data = flash_data;
    next_read_start = read_start;
    next_write_start = write_start;
    next_done_flag = flash_op_done_flag;
    next_ind_data = indirect_data_port;
    next_ind_valid = 1'b0;
    next_latch_valid = latch_valid;
    next_idx = idx;
    next_wdata = array_wdata;
    if (flash_addr_high_wr)
      next_flash_addr[`PFA_ADDR_W-1:`PFA_BYTE_W] = reg_wdata[`PFA_ADDR_HIGH_W-1:0];
    if (flash_addr_low_wr)
      next_flash_addr[`PFA_BYTE_W-1:0] = reg_wdata;
    if (flash_data_high_wr)
      next_flash_data[`PFA_WORD_W-1:`PFA_BYTE_W] = reg_wdata[`PFA_DATA_HIGH_W-1:0];
    if (flash_data_low_wr)
    begin
      next_flash_data[`PFA_BYTE_W-1:0] = reg_wdata;
      next_latch_valid[flash_addr[`PFA_ROW_IDX_W-1:0]] = 1'b1;
    end
    if (done_flag_clear)
      next_done_flag = 1'b0;
    case (state)
      pfa_idle:
      begin
        if (ind_rd_req && pointer_register[`PFA_IND_FLASH_BIT])
          next_state = pfa_ind;
        else if (read_start_set)
        begin
          next_read_start = 1'b1;
          next_state = pfa_read;
        end
        else if (array_erase_row)
        begin
          next_write_start = 1'b1;
          next_state = pfa_erase_wait;
        end
        else if (unlock_ok && write_permit && !erase_select && !protected_addr)
        begin
          // No erase precedes programming; cells must already be blank
          next_write_start = 1'b1;
          next_idx = `PFA_IDX_RESET;
          next_state = pfa_prog_fetch;
        end
        else if (write_start_set)
          next_write_start = 1'b0;
      end
      pfa_ind:
      begin
        next_ind_data = array_rdata[`PFA_BYTE_W-1:0];
        next_ind_valid = 1'b1;
        next_state = pfa_idle;
      end
      pfa_read:
      begin
        next_flash_data = array_rdata;
        next_read_start = 1'b0;
        next_state = pfa_idle;
      end
      pfa_erase_wait:
      begin
        if (array_done)
        begin
          next_write_start = 1'b0;
          next_done_flag = 1'b1;
          next_state = pfa_idle;
        end
      end
      pfa_prog_fetch:
      begin
        // Latch port is addressed with next_idx, so its data here matches idx
        if (latch_valid[idx])
        begin
          next_state = pfa_prog_issue;
          next_flash_addr[`PFA_ROW_IDX_W-1:0] = idx;
        end
        else if (idx == `PFA_IDX_LAST)
        begin
          next_write_start = 1'b0;
          next_done_flag = 1'b1;
          next_latch_valid = `PFA_MASK_RESET;
          next_state = pfa_idle;
        end
        else
          next_idx = idx + `PFA_IDX_STEP;
      end
      pfa_prog_issue:
      begin
        next_state = pfa_prog_wait;
      end
      pfa_prog_wait:
      begin
        if (array_done)
        begin
          next_latch_valid[idx] = 1'b0;
          if (idx == `PFA_IDX_LAST)
          begin
            next_write_start = 1'b0;
            next_done_flag = 1'b1;
            next_latch_valid = `PFA_MASK_RESET;
            next_state = pfa_idle;
          end
          else
          begin
            next_idx = idx + `PFA_IDX_STEP;
            next_state = pfa_prog_fetch;
          end
        end
      end
      default:
      begin
        next_state = pfa_idle;
      end
    endcase
    // Array can only clear bits, so the word sent is the latch itself
    if (state == pfa_prog_fetch)
      next_wdata = latch_rdata;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= pfa_idle;
      flash_addr <= `PFA_ADDR_RESET;
      flash_data <= `PFA_DATA_RESET;
      read_start <= 1'b0;
      write_start <= 1'b0;
      flash_op_done_flag <= 1'b0;
      indirect_data_port <= `PFA_BYTE_RESET;
      ind_rd_valid <= 1'b0;
      latch_valid <= '0;
      idx <= `PFA_IDX_RESET;
      array_wdata <= `PFA_DATA_RESET;
    end
    else
    begin
      state <= next_state;
      flash_addr <= next_flash_addr;
      flash_data <= next_flash_data;
      read_start <= next_read_start;
      write_start <= next_write_start;
      flash_op_done_flag <= next_done_flag;
      indirect_data_port <= next_ind_data;
      ind_rd_valid <= next_ind_valid;
      latch_valid <= next_latch_valid;
      idx <= next_idx;
      array_wdata <= next_wdata;
    end
  end
endmodule // pfa_ctrl
`default_nettype wire

// ---- verilog/pfa_defs.svh ----
// Constants for the program flash self-access controller
// Function
// - Indirect pointer read takes one cycle, stalls the CPU, returns one byte
// - Indirect pointer writes never program or erase flash
// - Flash words are 14 bits, grouped in rows of 32 words
// - Erase works on exactly one row, the smallest erasable unit
// - Erase sets bits to one, programming can only clear bits
// - Hidden 14-bit write latches are loaded through the data high/low pair
// - Any subset of a row may be programmed without erasing first
// - Read-start stalls the CPU, word lands in data registers next cycle
// - Data registers hold the word until next read or software write
// - Read-start bit clears itself when the read completes
// - Only an exact back-to-back unlock runs; any disturbance cancels it
// - Row erase and latch transfer both need a completed unlock
// - Write-start stalls the CPU until erase or write finishes
// - Write protection blocks self writes/erases, not external programmers
// - Code protection denies external access, self write/erase still work
// - Only an external bulk erase removes code protection, clearing everything
// - Self-programming offers no bulk erase, only row erase and write
// - User memory and IDs writable; ID, revision, configuration read-only
// - Starting a write never erases automatically
// - Protected row: write-start clears and no erase happens
// - Erase done sets done flag, irq if enabled; latches, permit unchanged
`ifndef PFA_DEFS_SVH
`define PFA_DEFS_SVH

`define PFA_WORD_W 14
`define PFA_ADDR_W 15
`define PFA_ROW_WORDS 32
`define PFA_ROW_IDX_W 5
`define PFA_ADDR_HIGH_W 7
`define PFA_DATA_HIGH_W 6
`define PFA_BYTE_W 8
`define PFA_KEY_FIRST 8'h55
`define PFA_KEY_SECOND 8'haa
`define PFA_USER_ID_COUNT 15'h0004
`define PFA_IND_FLASH_BIT 15
`define PFA_ADDR_RESET 15'h0000
`define PFA_DATA_RESET 14'h0000
`define PFA_BYTE_RESET 8'h00
`define PFA_MASK_RESET 32'h00000000
`define PFA_IDX_RESET 5'h00
`define PFA_IDX_LAST 5'h1f
`define PFA_IDX_STEP 5'h01

`endif

// ---- verilog/pfa_pkg.sv ----
// Types shared by the program flash self-access controller
package pfa_pkg;
  typedef enum logic [2:0] {pfa_idle, pfa_read, pfa_ind, pfa_erase_wait,
                            pfa_prog_fetch, pfa_prog_issue, pfa_prog_wait} pfa_state_t;
  typedef enum logic [1:0] {pfa_key_idle, pfa_key_first, pfa_key_second} pfa_key_state_t;
endpackage

// ---- verilog/pfa_latch_mem.sv ----
// Write latch storage for one flash row
`timescale 1ns/10ps
`default_nettype none
`include "pfa_defs.svh"
module pfa_latch_mem #(
  parameter int DEPTH = `PFA_ROW_WORDS,
  parameter int AW = `PFA_ROW_IDX_W,
  parameter int DW = `PFA_WORD_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // Read port, data one cycle after address
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [DEPTH];
  logic [DW-1:0] next_rdata;

  always_comb
  begin
    next_rdata = mem[raddr];
  end

  always_ff @(posedge clock)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata <= '0;
    end
    else
    begin
      rdata <= next_rdata;
    end
  end
endmodule // pfa_latch_mem
`default_nettype wire

// ---- verilog/pfa_unlock.sv ----
// Unlock key tracker
`timescale 1ns/10ps
`default_nettype none
`include "pfa_defs.svh"
module pfa_unlock (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Key register writes and write-start request
  input wire logic key_wr,
  input wire logic [`PFA_BYTE_W-1:0] key_data,
  input wire logic write_start_set,
  input wire logic disturb,
  // One-cycle grant, same cycle as write_start_set
  output logic unlock_ok
);
  import pfa_pkg::*;
  pfa_key_state_t state;
  pfa_key_state_t next_state;

  // ------------------------------------------------------------
  // Sequence tracking
  // ------------------------------------------------------------
  always_comb
  begin
    next_state = pfa_key_idle;
    unlock_ok = 1'b0;
    case (state)
      pfa_key_idle:
      begin
        if (key_wr && key_data == `PFA_KEY_FIRST && !disturb)
          next_state = pfa_key_first;
      end
      pfa_key_first:
      begin
        if (key_wr && key_data == `PFA_KEY_SECOND && !disturb)
          next_state = pfa_key_second;
        else if (key_wr && key_data == `PFA_KEY_FIRST && !disturb)
          next_state = pfa_key_first;
      end
      pfa_key_second:
      begin
        unlock_ok = write_start_set && !disturb;
        if (key_wr && key_data == `PFA_KEY_FIRST && !disturb)
          next_state = pfa_key_first;
      end
      default:
      begin
        next_state = pfa_key_idle;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= pfa_key_idle;
    end
    else
    begin
      state <= next_state;
    end
  end
endmodule // pfa_unlock
`default_nettype wire

// ---- tb/pfa_ctrl_monitor.sv ----
// Port checker for the flash self-access controller
`timescale 1ns/10ps
`default_nettype none
module pfa_ctrl_monitor (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Core side
  input wire logic read_start_set,
  input wire logic write_start_set,
  input wire logic unlock_key_register_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic disturb,
  input wire logic erase_select,
  input wire logic write_permit,
  input wire logic config_space_select,
  input wire logic flash_op_irq_enable,
  input wire logic ind_rd_req,
  input wire logic ind_wr_req,
  input wire logic [15:0] pointer_register,
  input wire logic storage_area_write_protect,
  input wire logic config_write_protect,
  input wire logic boot_write_protect,
  input wire logic app_write_protect,
  // Design outputs and array answer
  input wire logic read_start,
  input wire logic write_start,
  input wire logic cpu_stall,
  input wire logic flash_op_done_flag,
  input wire logic flash_op_irq,
  input wire logic ind_rd_valid,
  input wire logic array_rd,
  input wire logic array_erase_row,
  input wire logic array_prog,
  input wire logic [14:0] array_addr,
  input wire logic array_done
);
  // ----------------------------------------
  // Unlock history
  // ----------------------------------------
  // Own key tracker, so a wrong grant in the design cannot hide itself
  logic key_first;
  logic key_both;
  logic any_prot;
  assign any_prot = storage_area_write_protect | config_write_protect | boot_write_protect | app_write_protect;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      key_first <= 1'b0;
      key_both <= 1'b0;
    end
    else
    begin
      key_first <= unlock_key_register_wr && reg_wdata == 8'h55 && !disturb;
      key_both <= unlock_key_register_wr && reg_wdata == 8'haa && !disturb && key_first;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_read;
    read_start_set && !ind_rd_req && !write_start_set && !cpu_stall |->
      array_rd ##1 read_start && cpu_stall ##1 !read_start && !cpu_stall;
  endproperty
  a_read: assert property (p_read)
    else $error("word read timing wrong");
  property p_ind;
    ind_rd_req && pointer_register[15] && !read_start && !write_start |->
      cpu_stall && array_rd && array_addr == pointer_register[14:0] ##2 ind_rd_valid ##1 !ind_rd_valid;
  endproperty
  a_ind: assert property (p_ind)
    else $error("indirect read timing wrong");
  property p_ind_wr;
    ind_wr_req |-> !array_erase_row && !array_prog ##1 !write_start && !array_erase_row;
  endproperty
  a_ind_wr: assert property (p_ind_wr)
    else $error("indirect write touched the array");
  property p_erase;
    write_start_set && key_both && !disturb && erase_select && write_permit && !config_space_select && !any_prot
      |-> array_erase_row && cpu_stall ##1 write_start && cpu_stall;
  endproperty
  a_erase: assert property (p_erase)
    else $error("unlocked erase did not start");
  property p_refuse;
    write_start_set && !(key_both && !disturb) |-> !array_erase_row && !array_prog ##1 !write_start && !cpu_stall;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("operation ran without unlock");
  property p_prot;
    write_start_set && (!write_permit || (app_write_protect && boot_write_protect && storage_area_write_protect
      && config_write_protect)) |-> !array_erase_row ##1 !write_start && !array_erase_row;
  endproperty
  a_prot: assert property (p_prot)
    else $error("protected write or erase went ahead");
  property p_erase_end;
    array_done && erase_select && write_start |=> flash_op_done_flag && !write_start && !cpu_stall;
  endproperty
  a_erase_end: assert property (p_erase_end)
    else $error("erase end not reported");
  property p_stall;
    write_start && erase_select && !array_done |-> cpu_stall;
  endproperty
  a_stall: assert property (p_stall)
    else $error("core released during erase");
  property p_irq;
    flash_op_irq == (flash_op_done_flag && flash_op_irq_enable);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt does not follow flag and enable");
endmodule // pfa_ctrl_monitor
`default_nettype wire

// ---- tb/pfa_flash_model.sv ----
// Behavioural flash array with its timer
`timescale 1ns/10ps
`default_nettype none
module pfa_flash_model #(
  parameter int DELAY = 3
) (
  // Clock
  input wire logic clock,
  // Commands
  input wire logic array_rd,
  input wire logic array_erase_row,
  input wire logic array_prog,
  input wire logic array_space,
  input wire logic [14:0] array_addr,
  input wire logic [13:0] array_wdata,
  // Answers
  output logic [13:0] array_rdata,
  output logic array_done
);
  logic [13:0] mem [0:32767];
  logic [13:0] id_space [0:15];
  int busy;
  initial
  begin
    for (int i = 0; i < 32768; i++)
      mem[i] = 14'(i * 3);
    for (int i = 0; i < 16; i++)
      id_space[i] = 14'h3f00 | 14'(i);
    busy = 0;
    array_rdata = 14'h0000;
    array_done = 1'b0;
  end
  // Read data is good for one cycle only, then it toggles
  always @(posedge clock)
  begin
    array_done <= 1'b0;
    array_rdata <= ~array_rdata;
    if (array_rd)
      array_rdata <= array_space ? id_space[array_addr[3:0]] : mem[array_addr];
    if (array_erase_row && !array_space)
      for (int i = 0; i < 32; i++)
        mem[{array_addr[14:5], 5'(i)}] <= 14'h3fff;
    if (array_prog)
      mem[array_addr] <= mem[array_addr] & array_wdata;
    if (array_erase_row || array_prog)
      busy <= DELAY;
    else if (busy > 0)
    begin
      busy <= busy - 1;
      array_done <= (busy == 1);
    end
  end
endmodule // pfa_flash_model
`default_nettype wire

// ---- tb/tb_pfa_ctrl.sv ----
// Self-checking testbench for the flash self-access controller
`timescale 1ns/10ps
`default_nettype none
module tb_pfa_ctrl;
  logic clock = 1'b0, rst_n = 1'b0, flash_addr_high_wr = 1'b0, flash_addr_low_wr = 1'b0;
  logic flash_data_high_wr = 1'b0, flash_data_low_wr = 1'b0, config_space_select = 1'b0, erase_select = 1'b0;
  logic write_permit = 1'b0, read_start_set = 1'b0, write_start_set = 1'b0, unlock_key_register_wr = 1'b0;
  logic disturb = 1'b0, done_flag_clear = 1'b0, flash_op_irq_enable = 1'b0, ind_rd_req = 1'b0, ind_wr_req = 1'b0;
  logic code_protect = 1'b0, storage_area_write_protect = 1'b0, config_write_protect = 1'b0;
  logic boot_write_protect = 1'b0, app_write_protect = 1'b0, ext_bulk_erase_req = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [15:0] pointer_register = 16'h0000;
  logic [14:0] flash_addr, array_addr;
  logic [13:0] flash_data, array_wdata, array_rdata;
  logic [7:0] indirect_data_port;
  logic read_start, write_start, flash_op_done_flag, flash_op_irq, ind_rd_valid, cpu_stall, ext_access_allowed;
  logic ext_bulk_erase, array_rd, array_erase_row, array_prog, array_space, array_done;
  int fail_count = 0, comparisons = 0, cycles = 0;
  pfa_ctrl dut (.*);
  pfa_flash_model #(.DELAY(3)) u_array (.*);
  initial
  begin
    forever #2 clock = ~clock;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Every strobe is written once per edge, so back-to-back steps never clash
  task automatic strobe(input int s, input logic [7:0] d);
    @(posedge clock);
    reg_wdata <= d;
    flash_addr_high_wr <= (s == 0);
    flash_addr_low_wr <= (s == 1);
    flash_data_high_wr <= (s == 2);
    flash_data_low_wr <= (s == 3);
    unlock_key_register_wr <= (s == 4);
    read_start_set <= (s == 5);
    write_start_set <= (s == 6);
    ind_rd_req <= (s == 7);
    ind_wr_req <= (s == 8);
    done_flag_clear <= (s == 9);
    ext_bulk_erase_req <= (s == 10);
  endtask
  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
    while (cpu_stall !== 1'b0 || write_start !== 1'b0 || read_start !== 1'b0)
    begin
      @(posedge clock);
      #1;
    end
  endtask
  task automatic word_read(input logic cs, input logic [14:0] a, input logic [13:0] exp);
    @(posedge clock);
    config_space_select <= cs;
    strobe(0, {1'b0, a[14:8]});
    strobe(1, a[7:0]);
    strobe(5, 8'h00);
    strobe(15, 8'h00);
    settle();
    chk(flash_data, exp);
  endtask
  // Variant 1 sends a wrong second key, variant 2 leaves a gap
  task automatic unlock(input int k);
    strobe(4, 8'h55);
    if (k == 2)
      strobe(15, 8'h00);
    strobe(4, (k == 1) ? 8'hab : 8'haa);
    strobe(6, 8'h00);
    strobe(15, 8'h00);
  endtask
  task automatic load(input logic [7:0] lo, input logic [13:0] w);
    strobe(1, lo);
    strobe(2, {2'b00, w[13:8]});
    strobe(3, w[7:0]);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_read();
    word_read(1'b0, 15'h0123, 14'h0369);
    chk(read_start, 1'b0);
    repeat (3) @(posedge clock);
    #1 chk(flash_data, 14'h0369);
    word_read(1'b1, 15'h0002, 14'h3f02);
  endtask
  task automatic t_ind();
    @(posedge clock);
    pointer_register <= 16'h8045;
    strobe(7, 8'h00);
    strobe(15, 8'h00);
    repeat (3) @(posedge clock);
    #1 chk(indirect_data_port, 8'hcf);
    strobe(8, 8'h00);
    strobe(15, 8'h00);
    word_read(1'b0, 15'h0045, 14'h00cf);
  endtask
  task automatic t_erase();
    @(posedge clock);
    erase_select <= 1'b1;
    write_permit <= 1'b1;
    flash_op_irq_enable <= 1'b1;
    strobe(0, 8'h05);
    strobe(1, 8'h05);
    unlock(0);
    settle();
    chk(flash_op_done_flag, 1'b1);
    chk(flash_op_irq, 1'b1);
    strobe(9, 8'h00);
    strobe(15, 8'h00);
    #1 chk(flash_op_done_flag, 1'b0);
    word_read(1'b0, 15'h0505, 14'h3fff);
    word_read(1'b0, 15'h051f, 14'h3fff);
    word_read(1'b0, 15'h04ff, 14'h0efd);
  endtask
  task automatic t_prog();
    @(posedge clock);
    erase_select <= 1'b0;
    strobe(0, 8'h05);
    load(8'h03, 14'h1234);
    load(8'h07, 14'h0ff0);
    unlock(0);
    settle();
    chk(flash_op_done_flag, 1'b1);
    word_read(1'b0, 15'h0503, 14'h1234);
    word_read(1'b0, 15'h0504, 14'h3fff);
    word_read(1'b0, 15'h0507, 14'h0ff0);
    strobe(0, 8'h05);
    load(8'h03, 14'h3f0f);
    unlock(0);
    settle();
    word_read(1'b0, 15'h0503, 14'h1204);
  endtask
  task automatic t_refuse();
    @(posedge clock);
    erase_select <= 1'b1;
    for (int k = 1; k < 7; k++)
    begin
      @(posedge clock);
      disturb <= (k == 3);
      write_permit <= (k != 4);
      app_write_protect <= (k >= 5);
      storage_area_write_protect <= (k == 6);
      config_write_protect <= (k == 6);
      boot_write_protect <= (k == 6);
      unlock(k);
      #1 chk(write_start, 1'b0);
      chk(cpu_stall, 1'b0);
    end
    @(posedge clock);
    disturb <= 1'b0;
    app_write_protect <= 1'b0;
    storage_area_write_protect <= 1'b0;
    config_write_protect <= 1'b0;
    boot_write_protect <= 1'b0;
    word_read(1'b0, 15'h0503, 14'h1204);
  endtask
  task automatic t_ext();
    @(posedge clock);
    code_protect <= 1'b1;
    strobe(10, 8'h00);
    #1 chk(ext_bulk_erase, 1'b1);
    chk(ext_access_allowed, 1'b0);
    strobe(15, 8'h00);
    code_protect <= 1'b0;
    #1 chk(ext_access_allowed, 1'b1);
  endtask
  task automatic print_verdict();
    if (fail_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    t_read();
    t_ind();
    t_erase();
    t_prog();
    t_refuse();
    t_ext();
    repeat (4) @(posedge clock);
    print_verdict();
  end
endmodule // tb_pfa_ctrl
bind pfa_ctrl pfa_ctrl_monitor u_mon (.*);
`default_nettype wire
